// [core/asc_top.sv]
// Converter sequencer control: APB registers, divider, sequencer, result slots.
// Assumes the analog core delivers a result byte when told to sample, held stable.
`timescale 1ns/1ps
module asc_top (
    input wire logic CORE_CLK, // 250 MHz system clock
    input wire logic RST, // Synchronous reset, high
    input wire asc_pkg::asc_apb_req_s APB_REQ, // APB request
    output asc_pkg::asc_apb_rsp_s APB_RSP, // APB response
    input wire logic [7:0] ANA_RESULT, // Result from analog core
    output asc_pkg::asc_ana_req_s ANA_REQ, // Channel select and sample
    output logic IRQ // Interrupt request, high
);
    import asc_pkg::*;

    typedef struct packed {
        logic en;
        logic ie;
        logic start;
        logic [1:0] scan;
        logic rep;
        logic [3:0] chan;
        logic [5:0] timing;
        logic done;
        logic busy;
        logic ovf;
        logic [1:0] ptr;
        logic [3:0] full;
        logic [3:0][7:0] slot;
        asc_state_e st;
        logic [4:0] div_cnt;
        logic [6:0] tcnt;
        logic [1:0] step;
        logic stop_req;
        logic irq;
        asc_apb_rsp_s rsp;
        asc_ana_req_s ana;
    } asc_state_s;

    asc_state_s s_r;
    asc_state_s s_nxt;

    function automatic logic [6:0] pow2(input logic [2:0] code);
        pow2 = 7'h01 << code;
    endfunction : pow2

    // Power of two with reserved codes clamped to the largest legal one
    function automatic logic [6:0] code_span(input logic [2:0] code, input logic [2:0] top);
        code_span = pow2((code > top) ? top : code);
    endfunction : code_span

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    logic acc;
    logic wr;
    logic rd;
    logic tick;
    logic [7:0] wb;
    logic [2:0] cur_ch;
    logic [1:0] wptr;
    logic slot_rd;
    logic new_start;
    logic store_ev;

    always_comb begin
        s_nxt = s_r;
        acc = APB_REQ.psel && APB_REQ.penable && !s_r.rsp.pready;
        wr = acc && APB_REQ.pwrite;
        rd = acc && !APB_REQ.pwrite;
        wb = APB_REQ.pwdata[7:0];
        slot_rd = rd && APB_REQ.paddr >= ASC_OFF_SLOT0 && APB_REQ.paddr <= ASC_OFF_SLOT3
            && APB_REQ.paddr[1:0] == 2'h0;
        new_start = 1'b0;
        store_ev = 1'b0;
        wptr = s_r.ptr + 2'h1;
        cur_ch = s_r.chan[2:0] + ((s_r.scan == ASC_SCAN_FOUR) ? {1'b0, s_r.step} : 3'h0);
        s_nxt.rsp.pready = acc;
        s_nxt.rsp.pslverr = 1'b0;
        s_nxt.rsp.prdata = 32'h0;
        // Converter clock enable pulse
        tick = s_r.div_cnt == 5'(code_span(s_r.timing[2:0], ASC_DIV_MAX) - 7'h1);
        s_nxt.div_cnt = tick ? 5'h0 : s_r.div_cnt + 5'h1;
        s_nxt.ana.sample = 1'b0;
        // Register reads
        if (rd) begin
            case (APB_REQ.paddr)
                ASC_OFF_STATUS: s_nxt.rsp.prdata = {24'h0, 2'h0, s_r.ptr, 1'b0, s_r.ovf,
                    s_r.busy, s_r.done};
                ASC_OFF_ENABLE: s_nxt.rsp.prdata = {24'h0, 5'h0, s_r.ie, 1'b0, s_r.en};
                ASC_OFF_MODE: s_nxt.rsp.prdata = {24'h0, s_r.start, s_r.scan, s_r.rep, s_r.chan};
                ASC_OFF_TIMING: s_nxt.rsp.prdata = {24'h0, 2'h0, s_r.timing};
                default: begin
                    if (slot_rd) begin
                        s_nxt.rsp.prdata = {24'h0, s_r.slot[APB_REQ.paddr[3:2]]};
                    end else begin
                        s_nxt.rsp.pslverr = 1'b1;
                    end
                end
            endcase
        end
        if (slot_rd) begin
            s_nxt.done = 1'b0;
            s_nxt.irq = 1'b0;
            s_nxt.full[APB_REQ.paddr[3:2]] = 1'b0;
        end
        // Register writes
        if (wr) begin
            case (APB_REQ.paddr)
                ASC_OFF_STATUS: if (wb[ASC_BIT_OVF]) s_nxt.ovf = 1'b0;
                ASC_OFF_ENABLE: begin
                    s_nxt.en = wb[ASC_BIT_EN];
                    s_nxt.ie = wb[ASC_BIT_IE];
                end
                ASC_OFF_MODE: begin
                    if (!s_r.start) begin
                        s_nxt.scan = wb[6:5];
                        s_nxt.rep = wb[4];
                    end
                    s_nxt.chan = wb[3:0];
                    if (wb[ASC_BIT_START] && !s_r.start && s_r.en) begin
                        new_start = 1'b1;
                    end
                    s_nxt.start = wb[ASC_BIT_START] && s_r.en;
                    if (!wb[ASC_BIT_START] && s_r.start) s_nxt.stop_req = 1'b1;
                end
                ASC_OFF_TIMING: s_nxt.timing = wb[5:0] & ASC_MASK_TIMING[5:0];
                default: s_nxt.rsp.pslverr = 1'b1;
            endcase
        end
        // ------------------------------------------------------------
        // Sequencer
        // ------------------------------------------------------------
        case (s_r.st)
            ASC_IDLE: begin
                s_nxt.busy = 1'b0;
                if (new_start) begin
                    s_nxt.ptr = ASC_PTR_INIT;
                    s_nxt.step = 2'h0;
                    s_nxt.stop_req = 1'b0;
                    s_nxt.tcnt = 7'h0;
                    s_nxt.st = ASC_SAMPLE;
                    s_nxt.busy = 1'b1;
                end
            end
            ASC_SAMPLE: begin
                s_nxt.ana.channel = cur_ch;
                if (tick) begin
                    if (s_r.tcnt == code_span(s_r.timing[5:3], ASC_DLY_MAX) - 7'h1) begin
                        s_nxt.tcnt = 7'h0;
                        s_nxt.ana.sample = 1'b1;
                        s_nxt.st = ASC_CONVERT;
                    end else begin
                        s_nxt.tcnt = s_r.tcnt + 7'h1;
                    end
                end
            end
            ASC_CONVERT: begin
                if (tick) begin
                    if (s_r.tcnt == 7'(ASC_CONV_CYCLES - 4'h1)) begin
                        s_nxt.slot[wptr] = ANA_RESULT;
                        store_ev = 1'b1;
                        s_nxt.ptr = wptr;
                        s_nxt.full[wptr] = 1'b1;
                        if (s_r.full[wptr]) s_nxt.ovf = 1'b1;
                        s_nxt.tcnt = 7'h0;
                        s_nxt.step = s_r.step + 2'h1;
                        s_nxt.st = ASC_SAMPLE;
                        if ((s_r.scan != ASC_SCAN_FOUR && (!s_r.rep || s_r.stop_req))
                            || s_r.step == 2'h3) begin
                            s_nxt.done = 1'b1;
                            if (s_r.ie) s_nxt.irq = 1'b1;
                            if (!s_r.rep || s_r.stop_req || !s_nxt.start) begin
                                s_nxt.st = ASC_IDLE;
                                s_nxt.busy = 1'b0;
                                s_nxt.start = 1'b0;
                                s_nxt.stop_req = 1'b0;
                            end
                        end
                    end else begin
                        s_nxt.tcnt = s_r.tcnt + 7'h1;
                    end
                end
            end
            default: s_nxt.st = ASC_IDLE;
        endcase
        // Abort on disable
        if (!s_nxt.en) begin
            s_nxt.st = ASC_IDLE;
            s_nxt.done = 1'b0;
            s_nxt.busy = 1'b0;
            s_nxt.ovf = 1'b0;
            s_nxt.start = 1'b0;
            s_nxt.irq = 1'b0;
            s_nxt.stop_req = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            s_r <= '0;
            s_r.ptr <= ASC_PTR_INIT;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign APB_RSP = s_r.rsp;
    assign ANA_REQ = s_r.ana;
    assign IRQ = s_r.irq;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    chk_start_gated: assert property (!s_r.en |-> !s_r.start && !s_r.busy)
        else $error("start or busy while disabled");
    chk_disable_clears: assert property ($fell(s_r.en) |-> !s_r.done && !s_r.ovf && !IRQ)
        else $error("flags survive disable");
    chk_irq_needs_ie: assert property ($rose(IRQ) |-> s_r.ie && s_r.done)
        else $error("interrupt without enable");
    chk_mode_locked: assert property (s_r.start && $past(s_r.start) |-> $stable(s_r.scan))
        else $error("mode changed while started");
    chk_ptr_load: assert property ($rose(s_r.busy) |-> s_r.ptr == ASC_PTR_INIT)
        else $error("pointer not loaded");
    chk_read_clears: assert property (slot_rd && !store_ev |=> !s_r.done && !IRQ)
        else $error("result read kept interrupt");
    chk_single_stop: assert property ($fell(s_r.busy) && s_r.en && !s_r.rep |-> !s_r.start)
        else $error("start not cleared");
    chk_conv_len: assert property (
        $rose(s_r.ana.sample) && s_r.timing[2:0] == 3'h0
        |-> ##9 (s_r.ptr == $past(s_r.ptr, 9) || !s_r.en)
        ##1 (s_r.ptr == $past(s_r.ptr, 10) + 2'h1 || !s_r.en))
        else $error("conversion length wrong");
    cov_single: cover property ($fell(s_r.busy) && s_r.done);
    cov_overrun: cover property ($rose(s_r.ovf));
    cov_scan_irq: cover property ($rose(IRQ) && s_r.scan == ASC_SCAN_FOUR);
    cov_repeat_stop: cover property ($fell(s_r.busy) && s_r.rep);
    cov_abort: cover property ($fell(s_r.en) && $past(s_r.busy));

    // ----------------------------------------------------------------
    // Register bus checks
    // ----------------------------------------------------------------
    chk_ready_single: assert property (APB_RSP.pready |=> !APB_RSP.pready)
        else $error("ready held two cycles");
    chk_ready_follows: assert property (
        APB_REQ.psel && APB_REQ.penable && !APB_RSP.pready |=> APB_RSP.pready)
        else $error("access not answered");
    chk_err_with_ready: assert property (APB_RSP.pslverr |-> APB_RSP.pready)
        else $error("error without ready");
    chk_prdata_high: assert property (APB_RSP.prdata[31:8] == 24'h0)
        else $error("read data upper bytes set");

    // ----------------------------------------------------------------
    // Sequencer checks
    // ----------------------------------------------------------------
    chk_busy_state: assert property (s_r.busy == (s_r.st != ASC_IDLE))
        else $error("busy disagrees with state");
    chk_state_legal: assert property (s_r.st inside {ASC_IDLE, ASC_SAMPLE, ASC_CONVERT})
        else $error("illegal state");
    chk_sample_pulse: assert property (s_r.ana.sample |=> !s_r.ana.sample)
        else $error("sample pulse too long");
    chk_sample_in_conv: assert property (
        s_r.ana.sample |-> s_r.st == ASC_CONVERT || !s_r.en)
        else $error("sample outside conversion");
    chk_sample_on_tick: assert property ($rose(s_r.ana.sample) |-> $past(tick))
        else $error("sample off converter clock");
    chk_convert_entry: assert property (
        s_r.st == ASC_CONVERT && $past(s_r.st) != ASC_CONVERT |-> $past(s_r.st) == ASC_SAMPLE)
        else $error("conversion not after sampling");
    chk_start_entry: assert property (
        s_r.st == ASC_SAMPLE && $past(s_r.st) == ASC_IDLE |-> s_r.step == 2'h0 && s_r.ptr == ASC_PTR_INIT)
        else $error("sequence entry state wrong");
    chk_tcnt_bound: assert property (s_r.st == ASC_CONVERT |-> s_r.tcnt < 7'(ASC_CONV_CYCLES))
        else $error("conversion count overrun");
    chk_tcnt_delay: assert property (s_r.st == ASC_SAMPLE |-> s_r.tcnt < 7'h40)
        else $error("delay count overrun");
    chk_idle_quiet: assert property (s_r.st == ASC_IDLE |=> !s_r.ana.sample)
        else $error("sample from idle");
    chk_start_needs_en: assert property ($rose(s_r.start) |-> $past(s_r.en))
        else $error("start accepted while disabled");
    chk_busy_has_start: assert property ($rose(s_r.busy) |-> s_r.start)
        else $error("busy without start");
    chk_start_runs: assert property (s_r.start |-> s_r.busy)
        else $error("start without busy");
    chk_busy_needs_en: assert property (s_r.busy |-> s_r.en)
        else $error("busy while disabled");
    chk_stop_clears: assert property (
        store_ev && !s_r.rep && (s_r.scan != ASC_SCAN_FOUR || s_r.step == 2'h3)
        |=> !s_r.start && !s_r.busy)
        else $error("single cycle did not stop");

    // ----------------------------------------------------------------
    // Result checks
    // ----------------------------------------------------------------
    chk_store_ptr: assert property (store_ev |=> s_r.ptr == $past(s_r.ptr) + 2'h1)
        else $error("pointer not advanced");
    chk_store_full: assert property (store_ev |=> s_r.full[s_r.ptr])
        else $error("stored slot not marked");
    chk_store_tick: assert property (store_ev |-> tick)
        else $error("store off converter clock");
    chk_overrun_set: assert property (store_ev && s_r.full[wptr] |=> s_r.ovf || !s_r.en)
        else $error("overrun not flagged");
    chk_slot_stable: assert property (!store_ev |=> $stable(s_r.slot))
        else $error("slot changed without store");
    chk_ptr_idle: assert property (
        s_r.st == ASC_IDLE && !new_start |=> $stable(s_r.ptr))
        else $error("pointer moved while idle");
    chk_scan_ptr_end: assert property (
        store_ev && s_r.scan == ASC_SCAN_FOUR && s_r.step == 2'h3 |=> s_r.ptr == 2'h3)
        else $error("scan did not end at last slot");
    chk_done_sticky: assert property (
        s_r.done && !slot_rd && s_nxt.en |=> s_r.done)
        else $error("done lost without read");
    chk_done_source: assert property ($rose(s_r.done) |-> $past(store_ev))
        else $error("done without store");
    chk_ovf_sticky: assert property (
        s_r.ovf && !(wr && APB_REQ.paddr == ASC_OFF_STATUS && wb[ASC_BIT_OVF]) && s_nxt.en
        |=> s_r.ovf)
        else $error("overrun lost without clear");
    chk_done_at_end: assert property (
        store_ev && !s_r.rep && (s_r.scan != ASC_SCAN_FOUR || s_r.step == 2'h3)
        |=> s_r.done || !s_r.en)
        else $error("done not set at cycle end");
    chk_irq_with_done: assert property (IRQ |-> s_r.done)
        else $error("interrupt without done");
    chk_irq_source: assert property ($rose(IRQ) |-> $past(store_ev))
        else $error("interrupt without store");
    chk_irq_disabled: assert property (!s_r.en |-> !IRQ)
        else $error("interrupt while disabled");

    // ----------------------------------------------------------------
    // Divider and mode checks
    // ----------------------------------------------------------------
    chk_tick_single: assert property (
        tick && s_r.timing[2:0] != 3'h0 |=> !tick || s_r.timing[2:0] == 3'h0)
        else $error("converter clock pulse too long");
    chk_div_reset: assert property (tick |=> s_r.div_cnt == 5'h0)
        else $error("divider not restarted");
    chk_scan_held: assert property (!$stable(s_r.scan) |-> !$past(s_r.start))
        else $error("scan changed while started");
    chk_repeat_held: assert property (!$stable(s_r.rep) |-> !$past(s_r.start))
        else $error("repeat changed while started");
endmodule : asc_top

// [include/asc_pkg.sv]
// Constants, types and register map of the converter sequencer control.
// Assumes an APB master with 32-bit data and one clock domain.
//
// Contract
// - Start requests are honoured only while converter_enable (bit 0) is 1.
// - Clearing enable aborts conversion and clears done, busy, overrun and start.
// - irq_enable (bit 2) lets end of cycle raise the interrupt.
// - Channel field codes 0000..0111 pick inputs 0..7; top bit set reserved.
// - Scan and repeat fields ignore writes while start is already 1.
// - Scan field 00 is single channel, 01 is four-channel scan.
// - Repeat 0 stops after one cycle; repeat 1 repeats the cycle.
// - Single mode clears start at cycle end; repeat mode leaves it set.
// - Divider codes 000..101 divide system clock by 1..32; 110, 111 reserved.
// - Delay codes 000..110 give 1..64 converter clocks before sampling.
// - Results fill slots 0 to 3 in order; valid once done is set.
// - Each result is an 8-bit unsigned linear value, 00 to ff.
// - Reading any result slot withdraws the pending interrupt.
// - Mode, channel and start are accepted together from one write.
// - Reset clears every non-reserved bit of the three control registers.
// - Each conversion takes ten converter clocks after the sampling delay.
// - Done sets when results are stored; any result read clears it.
// - Storing over an unread slot overwrites it and sets sticky overrun.
// - Pointer loads 11 on start rise, increments per stored result.
package asc_pkg;
    localparam logic [11:0] ASC_OFF_STATUS = 12'h000;
    localparam logic [11:0] ASC_OFF_ENABLE = 12'h004;
    localparam logic [11:0] ASC_OFF_MODE = 12'h008;
    localparam logic [11:0] ASC_OFF_TIMING = 12'h00c;
    localparam logic [11:0] ASC_OFF_SLOT0 = 12'h010;
    localparam logic [11:0] ASC_OFF_SLOT3 = 12'h01c;
    localparam int ASC_BIT_EN = 0;
    localparam int ASC_BIT_IE = 2;
    localparam int ASC_BIT_START = 7;
    localparam int ASC_BIT_OVF = 2;
    localparam logic [7:0] ASC_MASK_ENABLE = 8'h05;
    localparam logic [7:0] ASC_MASK_TIMING = 8'h3f;
    localparam logic [1:0] ASC_PTR_INIT = 2'h3;
    localparam logic [1:0] ASC_SCAN_FOUR = 2'h1;
    localparam logic [3:0] ASC_CONV_CYCLES = 4'ha;
    localparam logic [2:0] ASC_DIV_MAX = 3'h5;
    localparam logic [2:0] ASC_DLY_MAX = 3'h6;

    typedef enum logic [1:0] {ASC_IDLE, ASC_SAMPLE, ASC_CONVERT} asc_state_e;

    typedef struct packed {
        logic [11:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } asc_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } asc_apb_rsp_s;

    typedef struct packed {
        logic [2:0] channel;
        logic sample;
    } asc_ana_req_s;
endpackage : asc_pkg

// [verification/asc_ana_model.sv]
// Behavioural analog core: one fixed level per input channel.
// Assumes sample pulses arrive in the system clock domain.
`timescale 1ns/1ps
module asc_ana_model (
    input wire logic clk, // System clock
    input wire asc_pkg::asc_ana_req_s req, // Channel select and sample
    output logic [7:0] result // Converted byte
);
    import asc_pkg::*;
    logic [7:0] level_r = 8'h00;
    // Held from one sample to the next
    always @(posedge clk) begin
        if (req.sample === 1'b1) begin
            level_r <= 8'(req.channel * 37 + 11);
        end
    end
    assign result = level_r;
endmodule : asc_ana_model

// [verification/tb_adc_sequencer_control.sv]
// Self-checking bench for the converter sequencer control.
// Assumes asc_pkg and the analog core model are compiled first.
`timescale 1ns/1ps
module tb_adc_sequencer_control;
    import asc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    asc_apb_req_s req = '0;
    asc_apb_rsp_s rsp;
    asc_ana_req_s ana;
    logic [7:0] res;
    logic irq;
    logic err_q;
    logic [7:0] q;
    logic [2:0] ch;
    int miscompares = 0;
    int n_tests = 0;
    int cyc = 0;
    int last = 0;
    int gap = 0;
    int nsamp = 0;
    always #2 clk = ~clk;
    asc_top uut (.CORE_CLK(clk), .RST(rst), .APB_REQ(req), .APB_RSP(rsp),
        .ANA_RESULT(res), .ANA_REQ(ana), .IRQ(irq));
    asc_ana_model ana_core (.clk(clk), .req(ana), .result(res));
    // Spacing of sample pulses in system cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (ana.sample === 1'b1) begin
            gap <= cyc - last;
            last <= cyc;
            nsamp <= nsamp + 1;
        end
    end
    // ------
    // Tasks
    // ------
    function automatic logic [7:0] exp_res(input logic [2:0] c);
        return 8'(c * 37 + 11);
    endfunction : exp_res
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk8
    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask : chk1
    task automatic chk_span(input int got, input int lo, input int hi);
        n_tests++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask : chk_span
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        req.paddr <= a;
        req.pwrite <= w;
        req.pwdata <= {24'h000000, d};
        req.psel <= 1'b1;
        @(posedge clk);
        req.penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (rsp.pready !== 1'b1);
        q = rsp.prdata[7:0];
        err_q = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk8(q & m, e);
    endtask : rd
    task automatic poll(input int b, input logic v);
        int n = 0;
        do begin
            apb(1'b0, ASC_OFF_STATUS, 8'h00);
            n++;
        end while (q[b] !== v && n < 2000);
        chk1(q[b], v);
    endtask : poll
    task automatic wait_samp(input int k);
        int t = nsamp + k;
        int n = 0;
        while (nsamp < t && n < 40000) begin
            @(posedge clk);
            n++;
        end
        chk1(nsamp >= t, 1'b1);
    endtask : wait_samp
    task automatic final_report();
        $display("comparisons=%0d mismatches=%0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report
    initial begin
        #360000;
        miscompares++;
        final_report();
    end
    // ------
    // Main sequence
    // ------
    initial begin
        void'($urandom(32'hea56a683));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd(ASC_OFF_STATUS, 8'hff, 8'h30);
        rd(ASC_OFF_ENABLE, 8'hff, 8'h00);
        rd(ASC_OFF_MODE, 8'hff, 8'h00);
        rd(ASC_OFF_TIMING, 8'hff, 8'h00);
        apb(1'b0, 12'h040, 8'h00);
        chk1(err_q, 1'b1);
        wr(ASC_OFF_MODE, 8'h80);
        rd(ASC_OFF_MODE, 8'h80, 8'h00);
        wr(ASC_OFF_ENABLE, 8'h05);
        repeat (25000) @(posedge clk);
        $display("test gate done");
        ch = 3'($urandom_range(7));
        wr(ASC_OFF_MODE, {5'h10, ch});
        poll(0, 1'b1);
        chk1(irq, 1'b1);
        rd(ASC_OFF_MODE, 8'hff, {5'h00, ch});
        rd(ASC_OFF_STATUS, 8'h37, 8'h01);
        rd(ASC_OFF_SLOT0, 8'hff, exp_res(ch));
        rd(ASC_OFF_STATUS, 8'h01, 8'h00);
        chk1(irq, 1'b0);
        $display("test single done");
        ch = 3'($urandom_range(7));
        wr(ASC_OFF_MODE, {5'h14, ch});
        poll(0, 1'b1);
        rd(ASC_OFF_STATUS, 8'h37, 8'h31);
        rd(ASC_OFF_MODE, 8'h80, 8'h00);
        for (int i = 0; i < 4; i++) begin
            rd(ASC_OFF_SLOT0 + 12'(4 * i), 8'hff, exp_res(ch + 3'(i)));
        end
        $display("test scan done");
        ch = 3'($urandom_range(7));
        wr(ASC_OFF_MODE, {5'h12, ch});
        poll(2, 1'b1);
        rd(ASC_OFF_MODE, 8'h80, 8'h80);
        wr(ASC_OFF_MODE, {5'h02, ch});
        poll(1, 1'b0);
        wr(ASC_OFF_STATUS, 8'h04);
        rd(ASC_OFF_STATUS, 8'h05, 8'h01);
        $display("test overrun done");
        for (int i = 0; i < 7; i++) begin
            wr(ASC_OFF_ENABLE, 8'h00);
            wr(ASC_OFF_TIMING, {2'h0, 3'(i), 3'(i % 6)});
            wr(ASC_OFF_ENABLE, 8'h01);
            wr(ASC_OFF_MODE, 8'h90);
            wait_samp(3);
            chk_span(gap, ((1 << i) + 9) << (i % 6), (((1 << i) + 12) << (i % 6)) + 8);
            wr(ASC_OFF_MODE, 8'ha0);
            rd(ASC_OFF_MODE, 8'hf0, 8'h90);
            wr(ASC_OFF_ENABLE, 8'h00);
            rd(ASC_OFF_STATUS, 8'h07, 8'h00);
            rd(ASC_OFF_MODE, 8'h80, 8'h00);
        end
        $display("test timing done");
        final_report();
    end
endmodule : tb_adc_sequencer_control
